// [logic/decc_pkg.sv]
// constants, field positions and types shared by the drawing-engine front end
// assumes a 16-bit host i/o port decode with full 16-bit port addresses
package decc_pkg;

	// ****************************************
	// port addresses
	// ****************************************
	localparam logic [15:0] ADDR_CFG_WR   = 16'h7aee; // engine_config_write
	localparam logic [15:0] ADDR_CFG_RD   = 16'h8eee; // engine_config_readback
	localparam logic [15:0] ADDR_LD_OPT   = 16'ha2ee; // linedraw options
	localparam logic [15:0] ADDR_LD_IDX   = 16'hfaee; // linedraw index
	localparam logic [15:0] ADDR_LINEDRAW = 16'hfeee; // linedraw point port
	localparam logic [15:0] ADDR_STEP     = 16'h96ee; // line_step_count
	localparam logic [15:0] ADDR_SSV      = 16'hc6ee; // short-vector command
	localparam logic [15:0] ADDR_SCANX    = 16'hcaee; // scan_end_x
	localparam logic [15:0] ADDR_BLITY    = 16'haeee; // blit_dest_y_last
	localparam logic [15:0] ADDR_STATUS   = 16'h62ee; // engine_status_ext
	localparam logic [15:0] ADDR_SUBSYS   = 16'h42e8; // subsystem control
	localparam logic [15:0] ADDR_SC_L     = 16'hdaee; // extended scissor bounds
	localparam logic [15:0] ADDR_SC_T     = 16'hdeee;
	localparam logic [15:0] ADDR_SC_R     = 16'he2ee;
	localparam logic [15:0] ADDR_SC_B     = 16'he6ee;
	localparam logic [15:0] ADDR_LG_L     = 16'hd2e8; // legacy scissor bounds
	localparam logic [15:0] ADDR_LG_T     = 16'hd6e8;
	localparam logic [15:0] ADDR_LG_R     = 16'hdae8;
	localparam logic [15:0] ADDR_LG_B     = 16'hdee8;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CFG_CM16_LSB  = 6;  // 16-bit colour layout
	localparam int CFG_PAR       = 8;  // parallel pixels to dac
	localparam int CFG_TRUEB     = 9;  // true-colour bytes per pixel
	localparam int CFG_ORDER     = 10; // true-colour byte order
	localparam int CFG_RS_LSB    = 12; // dac register select
	localparam int CFG_DAC8      = 14; // dac width
	localparam int OPT_CLIP_LSB  = 9;  // pre-clip mode
	localparam int SUB_IRQ_CLR   = 3;  // clear inside-scissor pending
	localparam int SUB_IRQ_EN    = 11; // inside_clip_irq_en
	localparam int ST_EXC        = 4;  // status: exception pending
	localparam int ST_IRQ        = 5;  // status: inside pending
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] OPT_RST = 16'h0000;
	localparam logic [11:0] SC_MIN  = 12'h800; // -2048
	localparam logic [11:0] SC_MAX  = 12'h7ff; // 2047
	localparam logic signed [15:0] DEV_MIN = -16'sd512;
	localparam logic signed [15:0] DEV_MAX = 16'sd1535;
	localparam logic [3:0] OVR_MAX = 4'hf;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0]
	{
		IDX_X0 = 3'b000, IDX_Y0 = 3'b001, IDX_X1 = 3'b010,
		IDX_Y1 = 3'b011, IDX_X2 = 3'b100, IDX_Y2 = 3'b101
	} decc_idx_e;
	typedef enum logic [1:0] {CLS_ACCEPT = 2'b00, CLS_REJECT = 2'b01, CLS_EXCEPT = 2'b10} decc_cls_e;
	typedef enum logic [1:0] {CLIP_MODE_OFF = 2'b00, CLIP_MODE_LINE = 2'b01,
		CLIP_MODE_POLY = 2'b10, CLIP_MODE_PAT = 2'b11} decc_clip_e;
	typedef enum logic {CST_OK = 1'b0, CST_EXC = 1'b1} decc_cst_e;
	typedef enum logic [2:0]
	{
		DK_STEP = 3'b000, DK_SSV = 3'b001, DK_SCAN = 3'b010, DK_LINE = 3'b011, DK_BLIT = 3'b100
	} decc_kind_e;
endpackage

// [logic/decc_cls_if.sv]
// link between the front end and its line pre-clip classifier
// assumes both ends sit in the same clock domain; the path is purely combinational
`timescale 1ns/10ps
interface decc_cls_if;
	logic signed [15:0]   x0;   // segment start
	logic signed [15:0]   y0;
	logic signed [15:0]   x1;   // segment end
	logic signed [15:0]   y1;
	logic signed [11:0]   sc_l; // scissor bounds
	logic signed [11:0]   sc_t;
	logic signed [11:0]   sc_r;
	logic signed [11:0]   sc_b;
	decc_pkg::decc_clip_e mode; // pre-clip mode
	decc_pkg::decc_cls_e  cls;  // verdict

	modport engine (output x0, y0, x1, y1, sc_l, sc_t, sc_r, sc_b, mode, input cls);
	modport classifier (input x0, y0, x1, y1, sc_l, sc_t, sc_r, sc_b, mode, output cls);
endinterface

// [logic/decc_classify.sv]
// line pre-clip classifier: accept, trivially reject, or raise an exception
// assumes endpoints are 16-bit signed and scissor bounds 12-bit signed
`timescale 1ns/10ps
module decc_classify
(
	// classifier side of the link
	decc_cls_if.classifier c
);
	logic out0, out1;       // endpoint outside device space
	logic bl, br, ba, bb;   // both left / right / above / below scissor
	logic poly_exc;         // polygon case whose clamping would bend the line
	logic signed [15:0] l, t, r, b;

	// sign-extend bounds to the endpoint width
	assign l = {{4{c.sc_l[11]}}, c.sc_l};
	assign t = {{4{c.sc_t[11]}}, c.sc_t};
	assign r = {{4{c.sc_r[11]}}, c.sc_r};
	assign b = {{4{c.sc_b[11]}}, c.sc_b};

	// device space limits what the draw engine can really rasterise
	assign out0 = (c.x0 < decc_pkg::DEV_MIN) || (c.x0 > decc_pkg::DEV_MAX) ||
		(c.y0 < decc_pkg::DEV_MIN) || (c.y0 > decc_pkg::DEV_MAX); // [RULE20]
	assign out1 = (c.x1 < decc_pkg::DEV_MIN) || (c.x1 > decc_pkg::DEV_MAX) ||
		(c.y1 < decc_pkg::DEV_MIN) || (c.y1 > decc_pkg::DEV_MAX);
	assign bl = (c.x0 <= l) && (c.x1 <= l);
	assign br = (c.x0 >= r) && (c.x1 >= r);
	assign ba = (c.y0 < t) && (c.y1 < t);
	assign bb = (c.y0 > b) && (c.y1 > b);
	assign poly_exc = ((c.x0 < decc_pkg::DEV_MIN) && (c.x1 > l)) ||
		((c.x1 < decc_pkg::DEV_MIN) && (c.x0 > l));

	// verdict per mode; off never rejects and never raises
	always_comb
	begin
		c.cls = decc_pkg::CLS_ACCEPT;
		case (c.mode) // [RULE18]
			decc_pkg::CLIP_MODE_LINE:
			begin
				if (bl || br || ba || bb)
					c.cls = decc_pkg::CLS_REJECT;
				else if (out0 || out1)
					c.cls = decc_pkg::CLS_EXCEPT;
			end
			decc_pkg::CLIP_MODE_POLY:
			begin
				// polygon edges beside the scissor are clamped, not dropped
				if (ba || bb)
					c.cls = decc_pkg::CLS_REJECT;
				else if (poly_exc || (out0 || out1) && !(bl || br))
					c.cls = decc_pkg::CLS_EXCEPT;
			end
			decc_pkg::CLIP_MODE_PAT:
			begin
				// patterned lines are drawn whole so the pattern index stays right
				if (out0 || out1)
					c.cls = decc_pkg::CLS_EXCEPT;
			end
			default:
				c.cls = decc_pkg::CLS_ACCEPT;
		endcase
	end
endmodule

// [logic/decc_top.sv]
// drawing-engine front end: configuration, draw triggers, scissor, point port, pre-clip
// assumes the host i/o strobes are one-cycle and synchronous to CLK, one access per cycle
//
// Function
// [RULE1] 16-bit colour packs per layout field
// [RULE2] parallel-pixel bit passes two units to dac
// [RULE3] bit 9 picks three or four bytes
// [RULE4] four-byte mode: spare byte set by order
// [RULE5] true-colour byte order per order field
// [RULE6] config 13:12 drive dac register selects
// [RULE7] config bit 14 picks dac width
// [RULE8] config readable at its readback port
// [RULE9] five trigger ports start drawing operations
// [RULE10] drawing coordinates valid -512 to 1535 only
// [RULE11] enabled inside-scissor draws raise an interrupt
// [RULE12] extended scissor bounds are 12-bit signed
// [RULE13] legacy bounds have narrower signed/unsigned ranges
// [RULE14] inside test: exclusive x, inclusive y
// [RULE15] short vectors under 16 pixels, 45 degree steps
// [RULE16] host loads index before point data
// [RULE17] each point write uses index, then increments
// [RULE18] clip mode selects off/line/polygon/pattern
// [RULE19] unclippable segment raises clip exception
// [RULE20] pre-clip accepts 16-bit signed endpoints
// [RULE21] after exception reject ends, count attempts
// [RULE22] overrun cleared by mode zero or Y
// [RULE23] rejected line moves pen without drawing
// [RULE24] accept or reject in the write cycle
// [RULE25] reset clears mode, index, exception, interrupt
`timescale 1ns/10ps
module decc_top
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// host i/o port
	input  wire logic [15:0] IO_ADDR,
	input  wire logic [15:0] IO_WDATA,
	input  wire logic        IO_WR,
	input  wire logic        IO_RD,
	output      logic [15:0] IO_RDATA,
	// pixel formatting
	input  wire logic [7:0]  COLOR_R,
	input  wire logic [7:0]  COLOR_G,
	input  wire logic [7:0]  COLOR_B,
	output      logic [15:0] PIX16,
	output      logic [31:0] PIXTC,
	output      logic        TC_FOUR_BYTES,
	// dac control
	output      logic [1:0]  DAC_RS,
	output      logic        DAC_8BIT,
	output      logic        DAC_PAR_PIXELS,
	// draw engine hand-off
	output      logic        DRAW_START,
	output      logic [2:0]  DRAW_KIND,
	output      logic [15:0] DRAW_DATA,
	output      logic [11:0] PEN_X,
	output      logic [11:0] PEN_Y,
	// events
	output      logic        CLIP_EXC,
	output      logic        INSIDE_IRQ
);
	// ****************************************
	// state
	// ****************************************
	logic [15:0]          cfg_q;       // engine_config_write image
	logic [15:0]          opt_q;       // linedraw options
	decc_pkg::decc_idx_e  idx_q;       // linedraw index
	logic signed [15:0]   pen_x_q;     // current position, full precision
	logic signed [15:0]   pen_y_q;
	logic signed [15:0]   end_x_q;     // latched end x
	logic signed [11:0]   sc_l_q, sc_t_q, sc_r_q, sc_b_q; // scissor bounds
	logic                 irq_en_q;    // inside_clip_irq_en
	logic                 irq_q;       // inside-scissor pending
	decc_pkg::decc_cst_e  cst_q;       // clip exception state
	logic [3:0]           ovr_q;       // clip overrun count
	logic [15:0]          rdata_q;     // read data
	logic                 start_q;     // draw start pulse
	logic [2:0]           kind_q;      // draw kind
	logic [15:0]          ddata_q;     // draw operand
	logic [15:0]          pix16_q;     // packed 16-bit colour
	logic [31:0]          pixtc_q;     // packed true colour

	// ****************************************
	// decode and same-cycle verdict
	// ****************************************
	logic wr_cfg, wr_opt, ld_wr, draw_y, reject_wr, new_exc, line_go, clr_ovr, trig_other, ins_hit;
	logic [2:0] trig_kind;
	logic [15:0] status;

	decc_cls_if cif ();

	// hand the pending segment to the classifier
	assign cif.x0   = pen_x_q;
	assign cif.y0   = pen_y_q;
	assign cif.x1   = end_x_q;
	assign cif.y1   = IO_WDATA;
	assign cif.sc_l = sc_l_q;
	assign cif.sc_t = sc_t_q;
	assign cif.sc_r = sc_r_q;
	assign cif.sc_b = sc_b_q;
	assign cif.mode = decc_pkg::decc_clip_e'(opt_q[decc_pkg::OPT_CLIP_LSB +: 2]);

	decc_classify u_cls
	(
		.c (cif.classifier)
	);

	// inside test on the full 16-bit coordinates against the 12-bit bounds
	function automatic logic in_scissor(input logic signed [15:0] x, input logic signed [15:0] y,
		input logic signed [11:0] l, input logic signed [11:0] t,
		input logic signed [11:0] r, input logic signed [11:0] b);
		in_scissor = (l < x) && (x < r) && (t <= y) && (y <= b); // [RULE14]
	endfunction

	assign wr_cfg    = IO_WR && (IO_ADDR == decc_pkg::ADDR_CFG_WR);
	assign wr_opt    = IO_WR && (IO_ADDR == decc_pkg::ADDR_LD_OPT);
	assign ld_wr     = IO_WR && (IO_ADDR == decc_pkg::ADDR_LINEDRAW);
	assign draw_y    = ld_wr && ((idx_q == decc_pkg::IDX_Y1) || (idx_q == decc_pkg::IDX_Y2));
	// decided combinationally so each refused write is counted in its own write cycle, saturating at 15
	assign reject_wr = draw_y && (cst_q == decc_pkg::CST_EXC); // [RULE24]
	assign new_exc   = draw_y && (cst_q == decc_pkg::CST_OK) && (cif.cls == decc_pkg::CLS_EXCEPT); // [RULE19]
	assign line_go   = draw_y && (cst_q == decc_pkg::CST_OK) && (cif.cls == decc_pkg::CLS_ACCEPT);
	assign clr_ovr   = (wr_opt && (IO_WDATA[decc_pkg::OPT_CLIP_LSB +: 2] == decc_pkg::CLIP_MODE_OFF)) ||
		(ld_wr && (idx_q == decc_pkg::IDX_Y0)); // [RULE22]

	// other trigger ports
	always_comb
	begin
		trig_other = IO_WR;
		trig_kind  = decc_pkg::DK_STEP;
		case (IO_ADDR) // [RULE9]
			decc_pkg::ADDR_STEP:  trig_kind = decc_pkg::DK_STEP;
			decc_pkg::ADDR_SSV:   trig_kind = decc_pkg::DK_SSV;
			decc_pkg::ADDR_SCANX: trig_kind = decc_pkg::DK_SCAN;
			decc_pkg::ADDR_BLITY: trig_kind = decc_pkg::DK_BLIT;
			default:              trig_other = 1'b0;
		endcase
	end

	// a draw touches the scissor if it starts inside it, or for a line if either end is inside it
	assign ins_hit = (trig_other && in_scissor(pen_x_q, pen_y_q, sc_l_q, sc_t_q, sc_r_q, sc_b_q)) ||
		(line_go && (in_scissor(pen_x_q, pen_y_q, sc_l_q, sc_t_q, sc_r_q, sc_b_q) ||
		in_scissor(end_x_q, IO_WDATA, sc_l_q, sc_t_q, sc_r_q, sc_b_q)));

	// status: index 8:6, inside pending 5, exception 4, overrun count 3:0
	assign status = {7'h00, 3'(idx_q), irq_q, (cst_q == decc_pkg::CST_EXC), ovr_q};

	// ****************************************
	// configuration and options
	// ****************************************
	// write-only config image; also readable at its readback port
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			cfg_q <= decc_pkg::CFG_RST;
		else if (wr_cfg)
			cfg_q <= IO_WDATA;
	end

	// options hold the pre-clip mode, zero after reset
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			opt_q <= decc_pkg::OPT_RST; // [RULE25]
		else if (wr_opt)
			opt_q <= IO_WDATA;
	end

	// subsystem control: enable and clear; a new hit beats the clear
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			irq_en_q <= 1'b0;
			irq_q    <= 1'b0;
		end
		else
		begin
			if (IO_WR && (IO_ADDR == decc_pkg::ADDR_SUBSYS))
				irq_en_q <= IO_WDATA[decc_pkg::SUB_IRQ_EN];
			if (irq_en_q && ins_hit)
				irq_q <= 1'b1; // [RULE11]
			else if (IO_WR && (IO_ADDR == decc_pkg::ADDR_SUBSYS) && IO_WDATA[decc_pkg::SUB_IRQ_CLR])
				irq_q <= 1'b0;
		end
	end

	// ****************************************
	// scissor bounds
	// ****************************************
	// legacy ports load the same bounds: left/top sign-extended, right/bottom zero-extended
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			sc_l_q <= decc_pkg::SC_MIN;
			sc_t_q <= decc_pkg::SC_MIN;
			sc_r_q <= decc_pkg::SC_MAX;
			sc_b_q <= decc_pkg::SC_MAX;
		end
		else if (IO_WR)
		begin
			case (IO_ADDR)
				decc_pkg::ADDR_SC_L: sc_l_q <= IO_WDATA[11:0]; // [RULE12]
				decc_pkg::ADDR_SC_T: sc_t_q <= IO_WDATA[11:0];
				decc_pkg::ADDR_SC_R: sc_r_q <= IO_WDATA[11:0];
				decc_pkg::ADDR_SC_B: sc_b_q <= IO_WDATA[11:0];
				decc_pkg::ADDR_LG_L: sc_l_q <= {IO_WDATA[10], IO_WDATA[10:0]}; // [RULE13]
				decc_pkg::ADDR_LG_T: sc_t_q <= {IO_WDATA[10], IO_WDATA[10:0]};
				decc_pkg::ADDR_LG_R: sc_r_q <= {1'b0, IO_WDATA[10:0]};
				decc_pkg::ADDR_LG_B: sc_b_q <= {1'b0, IO_WDATA[10:0]};
				default:             sc_l_q <= sc_l_q;
			endcase
		end
	end

	// ****************************************
	// point port
	// ****************************************
	// index steps by one per point write; the second end pair wraps back to the first
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			idx_q <= decc_pkg::IDX_X0; // [RULE25]
		else if (IO_WR && (IO_ADDR == decc_pkg::ADDR_LD_IDX))
			idx_q <= decc_pkg::decc_idx_e'(IO_WDATA[2:0]); // [RULE16]
		else if (ld_wr)
			idx_q <= (idx_q == decc_pkg::IDX_Y2) ? decc_pkg::IDX_X1 : decc_pkg::decc_idx_e'(idx_q + 3'h1); // [RULE17]
	end

	// pen and end latch; a rejected line still moves the pen, a refused write does not
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			pen_x_q <= '0;
			pen_y_q <= '0;
			end_x_q <= '0;
		end
		else if (ld_wr)
		begin
			case (idx_q)
				decc_pkg::IDX_X0: pen_x_q <= IO_WDATA;
				decc_pkg::IDX_Y0: pen_y_q <= IO_WDATA;
				decc_pkg::IDX_X1, decc_pkg::IDX_X2: end_x_q <= IO_WDATA;
				default:
				begin
					if (line_go || (draw_y && !reject_wr && !new_exc))
					begin
						pen_x_q <= end_x_q; // [RULE23]
						pen_y_q <= IO_WDATA;
					end
				end
			endcase
		end
	end

	// exception state and overrun count; the raising event wins over any clear
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			cst_q <= decc_pkg::CST_OK; // [RULE25]
			ovr_q <= '0;
		end
		else if (new_exc)
		begin
			cst_q <= decc_pkg::CST_EXC;
			ovr_q <= 4'h1;
		end
		else if (reject_wr)
			ovr_q <= (ovr_q == decc_pkg::OVR_MAX) ? ovr_q : ovr_q + 4'h1; // [RULE21]
		else if (clr_ovr)
		begin
			cst_q <= decc_pkg::CST_OK;
			ovr_q <= '0;
		end
	end

	// ****************************************
	// draw hand-off
	// ****************************************
	// one-cycle start pulse with its operand; short-vector length/direction ride in the operand
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			start_q <= 1'b0;
			kind_q  <= decc_pkg::DK_STEP;
			ddata_q <= '0;
		end
		else
		begin
			start_q <= trig_other || line_go;
			if (line_go)
				kind_q <= decc_pkg::DK_LINE;
			else if (trig_other)
				kind_q <= trig_kind; // [RULE15]
			if (trig_other || line_go)
				ddata_q <= IO_WDATA;
		end
	end

	// ****************************************
	// pixel packing and read port
	// ****************************************
	// colour layouts take the top bits of each 8-bit component
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			pix16_q <= '0;
		else
		begin
			case (cfg_q[decc_pkg::CFG_CM16_LSB +: 2]) // [RULE1]
				2'h0:    pix16_q <= {1'b0, COLOR_R[7:3], COLOR_G[7:3], COLOR_B[7:3]};
				2'h1:    pix16_q <= {COLOR_R[7:3], COLOR_G[7:2], COLOR_B[7:3]};
				2'h2:    pix16_q <= {COLOR_R[7:2], COLOR_G[7:3], COLOR_B[7:3]};
				default: pix16_q <= {COLOR_R[7:2], COLOR_G[7:2], COLOR_B[7:4]};
			endcase
		end
	end

	// true colour: order 0 keeps red-blue-green, spare byte at the bottom in four-byte mode
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			pixtc_q <= '0;
		else if (cfg_q[decc_pkg::CFG_ORDER])
			pixtc_q <= {8'h00, COLOR_B, COLOR_G, COLOR_R}; // [RULE5]
		else if (cfg_q[decc_pkg::CFG_TRUEB])
			pixtc_q <= {COLOR_R, COLOR_B, COLOR_G, 8'h00}; // [RULE4]
		else
			pixtc_q <= {8'h00, COLOR_R, COLOR_B, COLOR_G}; // [RULE3]
	end

	// read data held until the next read
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			rdata_q <= '0;
		else if (IO_RD)
		begin
			case (IO_ADDR)
				decc_pkg::ADDR_CFG_RD: rdata_q <= cfg_q; // [RULE8]
				decc_pkg::ADDR_LD_OPT: rdata_q <= opt_q;
				decc_pkg::ADDR_LD_IDX: rdata_q <= {13'h0000, 3'(idx_q)};
				decc_pkg::ADDR_STATUS: rdata_q <= {status[15:4], ovr_q};
				default:               rdata_q <= '0;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign IO_RDATA       = rdata_q;
	assign PIX16          = pix16_q;
	assign PIXTC          = pixtc_q;
	assign TC_FOUR_BYTES  = cfg_q[decc_pkg::CFG_TRUEB];
	assign DAC_RS         = cfg_q[decc_pkg::CFG_RS_LSB +: 2]; // [RULE6]
	assign DAC_8BIT       = cfg_q[decc_pkg::CFG_DAC8];        // [RULE7]
	assign DAC_PAR_PIXELS = cfg_q[decc_pkg::CFG_PAR];         // [RULE2]
	assign DRAW_START     = start_q;
	assign DRAW_KIND      = kind_q;
	assign DRAW_DATA      = ddata_q;
	assign PEN_X          = pen_x_q[11:0]; // [RULE10]
	assign PEN_Y          = pen_y_q[11:0];
	assign CLIP_EXC       = (cst_q == decc_pkg::CST_EXC);
	assign INSIDE_IRQ     = irq_q;

	// ****************************************
	// assertions
	// ****************************************
	sequence s_exc_then_reject;
		// the end-y that is refused comes after an end-x write, so never on the next edge
		new_exc ##1 (!reject_wr && !clr_ovr) [*3] ##1 reject_wr;
	endsequence
	property p_cfg_read;
		@(posedge CLK) disable iff (!RESET_N) (IO_RD && (IO_ADDR == decc_pkg::ADDR_CFG_RD)) |=> (IO_RDATA == $past(cfg_q));
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback mismatch"); // [RULE8]
	property p_dac;
		@(posedge CLK) disable iff (!RESET_N) wr_cfg |=> (DAC_RS == $past(IO_WDATA[13:12])) && (DAC_8BIT == $past(IO_WDATA[14]));
	endproperty
	a_dac: assert property (p_dac) else $error("dac controls do not follow config"); // [RULE6]
	property p_idx;
		@(posedge CLK) disable iff (!RESET_N) (ld_wr && (idx_q == decc_pkg::IDX_X0)) |=> (idx_q == decc_pkg::IDX_Y0);
	endproperty
	a_idx: assert property (p_idx) else $error("index did not step"); // [RULE17]
	property p_exc;
		@(posedge CLK) disable iff (!RESET_N) new_exc |=> CLIP_EXC && (ovr_q == 4'h1) && !DRAW_START;
	endproperty
	a_exc: assert property (p_exc) else $error("exception not raised"); // [RULE19]
	property p_ovr2;
		@(posedge CLK) disable iff (!RESET_N) s_exc_then_reject |=> (ovr_q == 4'h2) && CLIP_EXC;
	endproperty
	a_ovr2: assert property (p_ovr2) else $error("rejected write not counted"); // [RULE21]
	property p_clr;
		@(posedge CLK) disable iff (!RESET_N) (clr_ovr && !new_exc && !reject_wr) |=> (ovr_q == 4'h0) && !CLIP_EXC;
	endproperty
	a_clr: assert property (p_clr) else $error("overrun not cleared"); // [RULE22]
	property p_trig;
		@(posedge CLK) disable iff (!RESET_N) (IO_WR && (IO_ADDR == decc_pkg::ADDR_SSV)) |=> DRAW_START && (DRAW_KIND == decc_pkg::DK_SSV);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger did not start draw"); // [RULE9]
	property p_reject_move;
		@(posedge CLK) disable iff (!RESET_N) (draw_y && !reject_wr && (cif.cls == decc_pkg::CLS_REJECT)) |=> !DRAW_START && (pen_x_q == $past(end_x_q));
	endproperty
	a_reject_move: assert property (p_reject_move) else $error("rejected line drew or did not move"); // [RULE23]
endmodule

// [sim/decc_host.sv]
// host model: one i/o port access per call, strobe held for one edge
// assumes a single caller and the engine clock CLK
`timescale 1ns/10ps
module decc_host
(
	// engine clock
	input  wire logic        CLK,
	// host i/o port
	output      logic [15:0] IO_ADDR,
	output      logic [15:0] IO_WDATA,
	output      logic        IO_WR,
	output      logic        IO_RD
);
	initial {IO_ADDR, IO_WDATA, IO_WR, IO_RD} = 34'h0;
	// released bus shows inverted values so stale data never looks valid
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge CLK) #1;
		{IO_WR, IO_RD, IO_ADDR, IO_WDATA} = {w, !w, a, d};
		@(posedge CLK) #1;
		{IO_WR, IO_RD, IO_ADDR, IO_WDATA} = {2'b00, ~a, ~d};
	endtask
endmodule

// [sim/decc_top_bench.sv]
// self-checking bench for the drawing-engine front end
// assumes decc_host drives the port; reads and draw starts checked by a watcher
`timescale 1ns/10ps
module decc_top_bench;
	// ****************************************
	// signals and expectation queues
	// ****************************************
	logic        CLK = 1'b0;
	logic        RESET_N = 1'b0;
	logic [7:0]  r = 8'h00, g = 8'h00, b = 8'h00;
	logic [15:0] IO_ADDR, IO_WDATA, IO_RDATA, PIX16, DRAW_DATA, c, e;
	logic        IO_WR, IO_RD, TC4, DAC8, PAR, DRAW_START, CLIP_EXC, INSIDE_IRQ, rd_seen = 1'b0;
	logic [31:0] PIXTC, et, m, n;
	logic [1:0]  DAC_RS;
	logic [2:0]  DRAW_KIND;
	logic [11:0] PEN_X, PEN_Y;
	logic [31:0] rq[$];  // mask and value per read
	logic [18:0] dq[$];  // kind and data per draw start
	logic [15:0] ta[4] = '{decc_pkg::ADDR_STEP, decc_pkg::ADDR_SSV, decc_pkg::ADDR_SCANX, decc_pkg::ADDR_BLITY};
	logic [2:0]  tk[4] = '{3'd0, 3'd1, 3'd2, 3'd4};
	integer      seed = 32'hdc9b;
	int          err_count = 0;
	int          comparisons = 0;
	always #12.5 CLK = ~CLK;
	decc_host u_decc_host (.CLK(CLK), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD));
	decc_top u_decc_top
	(
		.CLK(CLK), .RESET_N(RESET_N), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD),
		.IO_RDATA(IO_RDATA), .COLOR_R(r), .COLOR_G(g), .COLOR_B(b), .PIX16(PIX16), .PIXTC(PIXTC),
		.TC_FOUR_BYTES(TC4), .DAC_RS(DAC_RS), .DAC_8BIT(DAC8), .DAC_PAR_PIXELS(PAR),
		.DRAW_START(DRAW_START), .DRAW_KIND(DRAW_KIND), .DRAW_DATA(DRAW_DATA), .PEN_X(PEN_X),
		.PEN_Y(PEN_Y), .CLIP_EXC(CLIP_EXC), .INSIDE_IRQ(INSIDE_IRQ)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons=%0d errors=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_decc_host.acc(1'b1, a, d);
	endtask
	// expectation is queued before the strobe so the watcher has it in time
	task automatic rd(input logic [15:0] a, input logic [15:0] msk, input logic [15:0] exp);
		rq.push_back({msk, exp});
		u_decc_host.acc(1'b0, a, 16'h0000);
	endtask
	task automatic trig(input logic [15:0] a, input logic [2:0] k, input logic [15:0] d);
		dq.push_back({k, d});
		wr(a, d);
	endtask
	task automatic tick;
		@(posedge CLK) #1;
	endtask
	// watcher: looks mid-cycle, after the edge's updates have landed
	always @(posedge CLK) rd_seen <= IO_RD;
	always @(negedge CLK)
	begin
		if (rd_seen)
		begin
			n = rq.size() ? rq.pop_front() : 32'h0000ffff;
			check(IO_RDATA & n[31:16], n[15:0]);
		end
		if (DRAW_START)
			check({DRAW_KIND, DRAW_DATA}, dq.size() ? dq.pop_front() : 19'h7ffff);
	end
	// watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge CLK);
		err_count++;
		tally_and_finish;
	end
	initial
	begin
		repeat (16) @(posedge CLK);
		#1 RESET_N = 1'b1;
		check({CLIP_EXC, INSIDE_IRQ, DRAW_START, DRAW_KIND}, 6'h00);
		rd(decc_pkg::ADDR_LD_OPT, 16'hffff, decc_pkg::OPT_RST);
		rd(decc_pkg::ADDR_LD_IDX, 16'h0007, 16'h0000);
		// every colour layout and true-colour size/order pairing
		for (int i = 0; i < 8; i++)
		begin
			c = 16'($random(seed));
			c = {1'b0, c[14:12], 1'b0, i[2:1], c[8], i[1:0], 6'h00};
			wr(decc_pkg::ADDR_CFG_WR, c);
			{r, g, b} = 24'($random(seed));
			tick;
			check({DAC_RS, DAC8, PAR, TC4}, {c[13:12], c[14], c[8], c[9]});
			case (i[1:0])
				2'd0: e = {1'b0, r[7:3], g[7:3], b[7:3]};
				2'd1: e = {r[7:3], g[7:2], b[7:3]};
				2'd2: e = {r[7:2], g[7:3], b[7:3]};
				default: e = {r[7:2], g[7:2], b[7:4]};
			endcase
			check(PIX16, e);
			m = (c[9] && !c[10]) ? 32'hffffff00 : 32'h00ffffff;
			et = c[10] ? {8'h0, b, g, r} : c[9] ? {r, b, g, 8'h0} : {8'h0, r, b, g};
			check(PIXTC & m, et);
			rd(decc_pkg::ADDR_CFG_RD, 16'hffff, c);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(decc_pkg::ADDR_LD_OPT, 16'(i << 9));
			rd(decc_pkg::ADDR_LD_OPT, 16'h0600, 16'(i << 9));
		end
		$display("config and modes done");
		wr(decc_pkg::ADDR_SUBSYS, 16'h0800);
		foreach (ta[j]) trig(ta[j], tk[j], 16'($random(seed)));
		tick;
		check(INSIDE_IRQ, 1'b1);
		wr(decc_pkg::ADDR_SUBSYS, 16'h0008);
		wr(decc_pkg::ADDR_SC_L, 16'h0000);
		wr(decc_pkg::ADDR_SUBSYS, 16'h0800);
		trig(decc_pkg::ADDR_STEP, 3'd0, 16'h0001);
		tick;
		check(INSIDE_IRQ, 1'b0);
		wr(decc_pkg::ADDR_LG_L, 16'h07ff);
		trig(decc_pkg::ADDR_STEP, 3'd0, 16'h0002);
		tick;
		check(INSIDE_IRQ, 1'b1);
		wr(decc_pkg::ADDR_SUBSYS, 16'h0008);
		$display("triggers and scissor done");
		// accepted line, then an unclippable one, then a refused end
		wr(decc_pkg::ADDR_LD_OPT, 16'h0200);
		wr(decc_pkg::ADDR_LD_IDX, 16'h0000);
		wr(decc_pkg::ADDR_LINEDRAW, 16'h0000);
		wr(decc_pkg::ADDR_LINEDRAW, 16'h0000);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd100);
		trig(decc_pkg::ADDR_LINEDRAW, 3'd3, 16'd50);
		rd(decc_pkg::ADDR_LD_IDX, 16'h0007, 16'h0004);
		check({PEN_X, PEN_Y}, {12'd100, 12'd50});
		wr(decc_pkg::ADDR_LINEDRAW, 16'hb1e0);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd100);
		check(CLIP_EXC, 1'b1);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd10);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd10);
		rd(decc_pkg::ADDR_STATUS, 16'h001f, 16'h0012);
		wr(decc_pkg::ADDR_LD_IDX, 16'h0000);
		wr(decc_pkg::ADDR_LINEDRAW, 16'hff38);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd10);
		rd(decc_pkg::ADDR_STATUS, 16'h001f, 16'h0000);
		wr(decc_pkg::ADDR_LINEDRAW, 16'hff9c);
		wr(decc_pkg::ADDR_LINEDRAW, 16'd20);
		tick;
		check({CLIP_EXC, PEN_X, PEN_Y}, {1'b0, 12'hf9c, 12'd20});
		check(rq.size() + dq.size(), 0);
		$display("point port done");
		tally_and_finish;
	end
endmodule
